// ---- ccar_pkg.sv ----
// constants, field positions and timing counts shared by both ends of the command/address link
// assumes a single 40 MHz core clock drives both ends and the software port of the controller
//
// Overview of operation
// RULE1 - capture all inputs on each rising clock edge
// RULE2 - reset low clears registers, outputs driven low
// RULE3 - both chip selects high hold gated outputs
// RULE4 - termination and clock-enable bits always update
// RULE5 - chip-select, termination, clock-enable outputs never held
// RULE6 - one-to-one mode gates outputs 2,3,5,6,8-25
// RULE7 - first one-to-two mode gates 2,3,5,6,8-14
// RULE8 - second one-to-two gates 1-6,8-10,12,13
// RULE9 - unused terminals idle, their outputs driven low
// RULE10 - controller always drives reset and configuration levels
// RULE11 - inputs may float only while reset low
// RULE12 - inputs low 10 ns after reset release
// RULE13 - inputs valid 15 ns after reset assertion
// RULE14 - fanout select picks width, bank select arrangement
// RULE15 - reset overrides chip-select hold and update
// RULE16 - one-to-two modes drive two identical output copies
// RULE17 - no clock edge, outputs hold captured values
package ccar_pkg;
  // ==========================================================
  // widths
  localparam int DATA_W = 25;
  localparam int HALF_W = 14;
  localparam int WORD_W = 26; // data bits plus auxiliary chip select
  localparam int FIFO_DEPTH = 16;
  // ==========================================================
  // bit positions inside the 25-bit input word (bit n-1 carries input n)
  localparam int CS_BIT = 6; // module chip select, active low
  localparam int CKE_BIT_1TO1 = 0;
  localparam int ODT_BIT_1TO1 = 3;
  localparam int CKE_BIT_A = 0;
  localparam int ODT_BIT_A = 3;
  localparam int CKE_BIT_B = 13;
  localparam int ODT_BIT_B = 10;
  localparam int AUX_CS_BIT = 25; // position in a queued command word
  // ==========================================================
  // gating and valid masks per configuration
  localparam logic [24:0] GATE_1TO1 = 25'h1ffffb6;
  localparam logic [24:0] GATE_A = 25'h0003fb6;
  localparam logic [24:0] GATE_B = 25'h0001bbf;
  localparam logic [24:0] VALID_1TO1 = 25'h1ffffff;
  localparam logic [24:0] VALID_1TO2 = 25'h0003fff;
  // ==========================================================
  // controller register map (byte addresses) and fields
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_CMD = 4'h4;
  localparam logic [3:0] REG_STATUS = 4'h8;
  localparam int CTRL_RUN_BIT = 0;
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_OVF_BIT = 2;
  localparam int ST_STATE_LSB = 3;
  localparam int ST_LEVEL_LSB = 8;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_PS = 25000;
  localparam int ACT_TIME_NS = 10;
  localparam int INACT_TIME_NS = 15;
  localparam int ACT_CYC_RAW = (ACT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int INACT_CYC_RAW = (INACT_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] ACT_CYC = 4'((ACT_CYC_RAW < 1) ? 1 : ACT_CYC_RAW);
  localparam logic [3:0] INACT_CYC = 4'((INACT_CYC_RAW < 1) ? 1 : INACT_CYC_RAW);
  // ==========================================================
  // controller link states
  typedef enum logic [1:0] {
    HST_IDLE = 2'b00,
    HST_ACTIVATE = 2'b01,
    HST_RUN = 2'b10,
    HST_DEACT = 2'b11
  } ccar_hst_t;
endpackage : ccar_pkg

// ---- ccar_link_if.sv ----
// link between the command controller and the registered buffer
// assumes both ends sit on the same core clock; drive_en low means the wires float
`timescale 1ns/10ps
interface ccar_link_if;
  logic reset_n; // device reset, active low
  logic drive_en; // controller is driving data and chip selects
  logic [24:0] data; // buffer inputs, module chip select at bit 6 (active low)
  logic aux_cs_n; // auxiliary chip select, active low
  modport host (output reset_n, output drive_en, output data, output aux_cs_n);
  modport dev (input reset_n, input drive_en, input data, input aux_cs_n);
endinterface : ccar_link_if

// ---- ccar_dev.sv ----
// registered command/address buffer: 25-bit one-to-one or 14-bit one-to-two
// assumes the link comes from logic on core_clk and the strap pins are static
`timescale 1ns/10ps
module ccar_dev (
  input wire logic core_clk, // capture clock
  input wire logic arst_n, // asynchronous reset, active low
  ccar_link_if.dev link, // controller side
  input wire logic bank_select, // strap: arrangement of one-to-two mode
  input wire logic fanout_select, // strap: one-to-one low, one-to-two high
  output logic [24:0] registered_outputs_a, // first output bank
  output logic [13:0] registered_outputs_b, // second output bank, low in one-to-one
  output logic [1:0] chip_sel_out, // registered chip select, bank a at bit 0
  output logic [1:0] term_ctrl_out, // registered termination control
  output logic [1:0] clk_en_out // registered clock enable
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] cfg_meta;
    logic [1:0] cfg;
    logic [24:0] q_a;
    logic [13:0] q_b;
    logic [1:0] cs_q;
    logic [1:0] odt_q;
    logic [1:0] cke_q;
  } ccar_dev_state_t;

  ccar_dev_state_t st;
  ccar_dev_state_t next_st;
  logic dev_rst_n;

  // link reset and local reset both clear the register
  assign dev_rst_n = arst_n & link.reset_n; // RULE2

  // ==========================================================
  // next state
  // straps pass two flops; until they settle the block runs as one-to-one
  always_comb
  begin
    logic [24:0] gate;
    logic [24:0] valid;
    logic [24:0] captured;
    logic suspend;
    logic one_to_two;
    int cke_pos;
    int odt_pos;
    gate = ccar_pkg::GATE_1TO1;
    valid = ccar_pkg::VALID_1TO1;
    captured = 25'h0000000;
    suspend = 1'b0;
    one_to_two = 1'b0;
    cke_pos = ccar_pkg::CKE_BIT_1TO1;
    odt_pos = ccar_pkg::ODT_BIT_1TO1;
    next_st = st;
    next_st.cfg_meta = {fanout_select, bank_select};
    next_st.cfg = st.cfg_meta;
    // fanout select picks width, bank select the arrangement
    one_to_two = st.cfg[1]; // RULE14
    if (!one_to_two)
    begin
      gate = ccar_pkg::GATE_1TO1; // RULE6
      valid = ccar_pkg::VALID_1TO1;
      cke_pos = ccar_pkg::CKE_BIT_1TO1;
      odt_pos = ccar_pkg::ODT_BIT_1TO1;
    end
    else if (!st.cfg[0])
    begin
      gate = ccar_pkg::GATE_A; // RULE7
      valid = ccar_pkg::VALID_1TO2;
      cke_pos = ccar_pkg::CKE_BIT_A;
      odt_pos = ccar_pkg::ODT_BIT_A;
    end
    else
    begin
      gate = ccar_pkg::GATE_B; // RULE8
      valid = ccar_pkg::VALID_1TO2;
      cke_pos = ccar_pkg::CKE_BIT_B;
      odt_pos = ccar_pkg::ODT_BIT_B;
    end
    // unused inputs are ignored, so their outputs stay low
    captured = link.data & valid; // RULE9
    suspend = link.data[ccar_pkg::CS_BIT] & link.aux_cs_n;
    // gated bits keep their value while both selects are high
    for (int i = 0; i < ccar_pkg::DATA_W; i++)
    begin
      if (gate[i] && suspend)
        next_st.q_a[i] = st.q_a[i]; // RULE3
      else
        next_st.q_a[i] = captured[i]; // RULE1
    end
    // second bank copies the first in one-to-two, idles low otherwise
    next_st.q_b = one_to_two ? next_st.q_a[13:0] : 14'h0000; // RULE16 RULE9
    // select, termination and clock-enable bits load on every edge
    next_st.cs_q = {one_to_two & captured[ccar_pkg::CS_BIT], captured[ccar_pkg::CS_BIT]}; // RULE5
    next_st.odt_q = {one_to_two & captured[odt_pos], captured[odt_pos]}; // RULE4 RULE5
    next_st.cke_q = {one_to_two & captured[cke_pos], captured[cke_pos]}; // RULE4 RULE5
  end

  // ==========================================================
  // register; between edges only reset changes it
  always_ff @(posedge core_clk or negedge dev_rst_n)
  begin
    if (!dev_rst_n)
      st <= '0; // RULE2 RULE15
    else
      st <= next_st; // RULE17
  end

  // ==========================================================
  // outputs straight from flops
  assign registered_outputs_a = st.q_a;
  assign registered_outputs_b = st.q_b;
  assign chip_sel_out = st.cs_q;
  assign term_ctrl_out = st.odt_q;
  assign clk_en_out = st.cke_q;
endmodule : ccar_dev

// ---- ccar_host.sv ----
// command controller driving the buffer link, with its command queue
// assumes a software master on core_clk using one-cycle strobes, read data one cycle later
`timescale 1ns/10ps
module ccar_fifo #(
  parameter int WIDTH = 26,
  parameter int DEPTH = 16
) (
  input wire logic core_clk, // clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic in_valid, // push request
  output logic in_ready, // not full
  input wire logic [WIDTH-1:0] in_data, // pushed word
  output logic out_valid, // not empty
  input wire logic out_ready, // pop request
  output logic [WIDTH-1:0] out_data, // head word
  output logic [$clog2(DEPTH):0] level // words held
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
  } ccar_fifo_state_t;

  ccar_fifo_state_t st;
  ccar_fifo_state_t next_st;
  logic full;
  logic empty;

  // extra pointer bit tells full from empty
  assign full = (st.wr_ptr[AW] != st.rd_ptr[AW]) && (st.wr_ptr[AW-1:0] == st.rd_ptr[AW-1:0]);
  assign empty = (st.wr_ptr == st.rd_ptr);
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = st.mem[st.rd_ptr[AW-1:0]];
  assign level = st.wr_ptr - st.rd_ptr;

  // push and pop
  always_comb
  begin
    next_st = st;
    if (in_valid && !full)
    begin
      next_st.mem[st.wr_ptr[AW-1:0]] = in_data;
      next_st.wr_ptr = st.wr_ptr + {{AW{1'b0}}, 1'b1};
    end
    if (out_ready && !empty)
      next_st.rd_ptr = st.rd_ptr + {{AW{1'b0}}, 1'b1};
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : ccar_fifo

module ccar_host (
  input wire logic core_clk, // clock
  input wire logic arst_n, // asynchronous reset, active low
  input wire logic [3:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, valid the cycle after rd
  ccar_link_if.host link // buffer side
);
  // ==========================================================
  // state
  typedef struct packed {
    ccar_pkg::ccar_hst_t state;
    logic [3:0] cnt;
    logic run;
    logic ovf;
    logic [31:0] rdata;
    logic reset_n;
    logic drive_en;
    logic [24:0] data;
    logic aux_cs_n;
  } ccar_host_state_t;

  ccar_host_state_t st;
  ccar_host_state_t next_st;
  logic push;
  logic in_ready;
  logic out_valid;
  logic pop;
  logic [25:0] head;
  logic [4:0] level;

  assign push = wr && (addr == ccar_pkg::REG_CMD);
  // no pop once run is cleared, or the word would vanish with the link going down
  assign pop = (st.state == ccar_pkg::HST_RUN) && st.run && out_valid;

  // ==========================================================
  // command queue; the link drains it only while running
  ccar_fifo #(
    .WIDTH(ccar_pkg::WORD_W),
    .DEPTH(ccar_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .in_valid(push),
    .in_ready(in_ready),
    .in_data(wdata[25:0]),
    .out_valid(out_valid),
    .out_ready(pop),
    .out_data(head),
    .level(level)
  );

  // ==========================================================
  // register port and link sequencing
  always_comb
  begin
    next_st = st;
    next_st.rdata = 32'h00000000;
    if (wr && addr == ccar_pkg::REG_CTRL)
      next_st.run = wdata[ccar_pkg::CTRL_RUN_BIT];
    // a write into a full queue is dropped; overflow set wins over its clear
    if (wr && addr == ccar_pkg::REG_STATUS && wdata[ccar_pkg::ST_OVF_BIT])
      next_st.ovf = 1'b0;
    if (push && !in_ready)
      next_st.ovf = 1'b1;
    if (rd)
    begin
      unique case (addr)
        ccar_pkg::REG_CTRL: next_st.rdata[ccar_pkg::CTRL_RUN_BIT] = st.run;
        ccar_pkg::REG_STATUS:
        begin
          next_st.rdata[ccar_pkg::ST_EMPTY_BIT] = !out_valid;
          next_st.rdata[ccar_pkg::ST_FULL_BIT] = !in_ready;
          next_st.rdata[ccar_pkg::ST_OVF_BIT] = st.ovf;
          next_st.rdata[ccar_pkg::ST_STATE_LSB +: 2] = st.state;
          next_st.rdata[ccar_pkg::ST_LEVEL_LSB +: 5] = level;
        end
        default: next_st.rdata = 32'h00000000;
      endcase
    end
    if (st.cnt != 4'h0)
      next_st.cnt = st.cnt - 4'h1;
    unique case (st.state)
      ccar_pkg::HST_IDLE:
      begin
        // link floats only with the device held in reset
        next_st.reset_n = 1'b0; // RULE10 RULE11
        next_st.drive_en = 1'b0; // RULE11
        next_st.data = 25'h0000000;
        next_st.aux_cs_n = 1'b1;
        if (st.run)
        begin
          next_st.drive_en = 1'b1;
          next_st.reset_n = 1'b1;
          next_st.cnt = ccar_pkg::ACT_CYC;
          next_st.state = ccar_pkg::HST_ACTIVATE;
        end
      end
      ccar_pkg::HST_ACTIVATE:
      begin
        // inputs stay low while the receivers wake up
        next_st.data = 25'h0000000; // RULE12
        if (st.cnt == 4'h0)
          next_st.state = ccar_pkg::HST_RUN;
      end
      ccar_pkg::HST_RUN:
      begin
        if (pop)
        begin
          next_st.data = head[24:0];
          next_st.aux_cs_n = head[ccar_pkg::AUX_CS_BIT];
        end
        else
        begin
          // nothing queued: deselect so the gated outputs hold
          next_st.data[ccar_pkg::CS_BIT] = 1'b1;
          next_st.aux_cs_n = 1'b1;
        end
        if (!st.run)
        begin
          next_st.reset_n = 1'b0;
          next_st.data = 25'h0000000;
          next_st.aux_cs_n = 1'b1;
          next_st.cnt = ccar_pkg::INACT_CYC;
          next_st.state = ccar_pkg::HST_DEACT;
        end
      end
      ccar_pkg::HST_DEACT:
      begin
        // keep driving valid levels after reset goes low
        if (st.cnt == 4'h0)
        begin
          next_st.drive_en = 1'b0; // RULE13
          next_st.state = ccar_pkg::HST_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st <= '0;
      st.aux_cs_n <= 1'b1;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // outputs straight from flops
  assign rdata = st.rdata;
  assign link.reset_n = st.reset_n;
  assign link.drive_en = st.drive_en;
  assign link.data = st.data;
  assign link.aux_cs_n = st.aux_cs_n;
endmodule : ccar_host

// ---- ccar_link_properties.sv ----
// checker for the link between the command controller and the registered buffer
// assumes one core clock; placed in the bench beside the link interface
`timescale 1ns/10ps
module ccar_link_properties (
  input wire logic core_clk, // clock
  input wire logic arst_n, // reset, active low
  input wire logic reset_n, // device reset on the link
  input wire logic drive_en, // controller drives the wires
  input wire logic [24:0] data, // buffer inputs
  input wire logic aux_cs_n // auxiliary chip select
);
  // ==========================================================
  // every check shares the core clock and its reset
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  // wires may float only while the device is held in reset
  chk_float_in_reset: assert property (!drive_en |-> !reset_n)
    else $error("link floats while device is out of reset");
  chk_wake_together: assert property ($rose(reset_n) |-> $rose(drive_en))
    else $error("reset released without driven wires");
  chk_wake_data_low: assert property ($rose(reset_n) |-> (data == 25'h0) [*2])
    else $error("data not low after reset release");
  chk_wake_stays_up: assert property ($rose(reset_n) |=> reset_n [*2])
    else $error("reset released only briefly");
  chk_sleep_driven: assert property ($fell(reset_n) |-> drive_en)
    else $error("wires released with reset entry");
  chk_sleep_bounded: assert property ($fell(reset_n) |-> ##[1:4] !drive_en)
    else $error("wires never released after reset entry");
  chk_release_order: assert property ($fell(drive_en) |-> !$past(reset_n))
    else $error("wires released before reset was held");
  // a quiet link in reset keeps the auxiliary select high and data low
  chk_sleep_quiet: assert property (!reset_n |-> (data == 25'h0) && aux_cs_n)
    else $error("link not quiet while device in reset");
endmodule : ccar_link_properties

// ---- tb.sv ----
// testbench: controller and buffer joined by the link, driven over the register port
// assumes package, interface and design files are compiled first
`timescale 1ns/10ps
module tb;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic bank_select = 1'b0;
  logic fanout_select = 1'b0;
  logic [24:0] q_a;
  logic [13:0] q_b;
  logic [1:0] cs_q;
  logic [1:0] odt_q;
  logic [1:0] cke_q;
  logic [24:0] mdl_a = 25'h0;
  int failures = 0;
  int checks_done = 0;
  // ==========================================================
  // design, link and checker
  ccar_link_if link ();
  ccar_host u_ccar_host (.core_clk(core_clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .link(link));
  ccar_dev u_ccar_dev (.core_clk(core_clk), .arst_n(arst_n), .link(link),
    .bank_select(bank_select), .fanout_select(fanout_select), .registered_outputs_a(q_a),
    .registered_outputs_b(q_b), .chip_sel_out(cs_q), .term_ctrl_out(odt_q), .clk_en_out(cke_q));
  ccar_link_properties u_ccar_link_properties (.core_clk(core_clk), .arst_n(arst_n),
    .reset_n(link.reset_n), .drive_en(link.drive_en), .data(link.data),
    .aux_cs_n(link.aux_cs_n));
  // 25 ns core clock
  always #12.5 core_clk = ~core_clk;
  // ==========================================================
  // compare and bus tasks
  task automatic chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg
  task automatic chk_out(input string nm, input logic [44:0] e);
    checks_done++;
    if ({q_a, q_b, cs_q, odt_q, cke_q} !== e)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, {q_a, q_b, cs_q, odt_q, cke_q});
    end
  endtask : chk_out
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1;
    chk_reg("rdata", e, rdata);
  endtask : rd_reg
  // bounded wait for the link reset level; running out ends the run
  task automatic wait_link(input logic lvl);
    int n;
    n = 0;
    while (link.reset_n !== lvl && n < 20)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (link.reset_n !== lvl)
    begin
      failures++;
      $display("MISMATCH link reset expected %b seen %b", lvl, link.reset_n);
      tally_and_finish();
    end
  endtask : wait_link
  // ==========================================================
  // reference model: gated bits hold unless a select is low, idle raises the select
  function automatic logic [24:0] settle(input logic [25:0] w, input logic [24:0] prev);
    logic [24:0] g;
    logic [24:0] ld;
    g = !fanout_select ? ccar_pkg::GATE_1TO1 : (bank_select ? ccar_pkg::GATE_B : ccar_pkg::GATE_A);
    ld = (!w[6] || !w[25]) ? w[24:0] : ((w[24:0] & ~g) | (prev & g));
    return (ld | 25'h40) & (fanout_select ? ccar_pkg::VALID_1TO2 : ccar_pkg::VALID_1TO1);
  endfunction : settle
  function automatic logic [44:0] exp_out(input logic [24:0] a);
    int ck;
    int od;
    ck = (fanout_select && bank_select) ? ccar_pkg::CKE_BIT_B : ccar_pkg::CKE_BIT_A;
    od = (fanout_select && bank_select) ? ccar_pkg::ODT_BIT_B : ccar_pkg::ODT_BIT_A;
    return {a, fanout_select ? a[13:0] : 14'h0, fanout_select & a[6], a[6],
      fanout_select & a[od], a[od], fanout_select & a[ck], a[ck]};
  endfunction : exp_out
  // ==========================================================
  // scenarios
  task automatic start_run(input logic fan, input logic bank);
    @(posedge core_clk);
    arst_n <= 1'b0;
    fanout_select <= fan;
    bank_select <= bank;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    mdl_a = 25'h0;
    wr_reg(ccar_pkg::REG_CTRL, 32'h1);
    wait_link(1'b1);
    repeat (4) @(posedge core_clk);
    #1;
    mdl_a = settle(26'h0, mdl_a);
    chk_out("wake", exp_out(mdl_a));
  endtask : start_run
  task automatic send(input logic [25:0] w);
    wr_reg(ccar_pkg::REG_CMD, {6'h0, w});
    repeat (5) @(posedge core_clk);
    #1;
    mdl_a = settle(w, mdl_a);
    chk_out("outputs", exp_out(mdl_a));
  endtask : send
  task automatic t_mode(input logic fan, input logic bank);
    start_run(fan, bank);
    send(26'h1ffffff);
    send(26'h2000040);
    send(26'h20aaa2a);
    send(26'h1555555);
    $display("test mode %b%b done", fan, bank);
  endtask : t_mode
  // stop drops the link reset, which clears the buffer
  task automatic t_stop();
    wr_reg(ccar_pkg::REG_CTRL, 32'h0);
    wait_link(1'b0);
    chk_out("stopped", 45'h0);
    $display("test stop done");
  endtask : t_stop
  // queue overfills while stopped, then drains back to back
  task automatic t_fifo();
    repeat (17) wr_reg(ccar_pkg::REG_CMD, 32'h0123456);
    rd_reg(ccar_pkg::REG_STATUS, 32'h1006);
    wr_reg(ccar_pkg::REG_CTRL, 32'h1);
    wait_link(1'b1);
    repeat (24) @(posedge core_clk);
    rd_reg(ccar_pkg::REG_STATUS, 32'h15);
    wr_reg(ccar_pkg::REG_STATUS, 32'h4);
    rd_reg(ccar_pkg::REG_STATUS, 32'h11);
    rd_reg(ccar_pkg::REG_CTRL, 32'h1);
    rd_reg(4'hc, 32'h0);
    #1;
    chk_out("drained", exp_out(settle(26'h0123456, 25'h0)));
    $display("test queue done");
  endtask : t_fifo
  // reset in mid-run clears outputs without waiting for an edge
  task automatic t_reset_prio();
    @(posedge core_clk);
    arst_n <= 1'b0;
    #1;
    chk_out("reset", 45'h0);
    $display("test reset done");
  endtask : t_reset_prio
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish
  // main sequence
  initial
  begin
    t_mode(1'b0, 1'b0);
    t_mode(1'b1, 1'b0);
    t_mode(1'b1, 1'b1);
    t_mode(1'b0, 1'b1);
    t_stop();
    t_fifo();
    t_reset_prio();
    tally_and_finish();
  end
endmodule : tb
